// File: dv/egds_host.sv
module egds_host (
  // Requests towards the bank.
  input wire logic clk,
  output logic [6:0] reg_addr,
  output logic reg_rd,
  output logic reg_wr,
  output logic [15:0] reg_wdata,
  // Answer.
  input wire logic [15:0] reg_rdata,
  input wire logic reg_hit
);
  timeunit 1ns / 1ps;
  initial {reg_rd, reg_wr, reg_addr, reg_wdata} = '0;
  // One strobe cycle; the answer is taken a cycle later, then the bus is let go.
  task automatic acc(logic w, logic [6:0] a, logic [15:0] wd, output logic [15:0] d,
                     output logic h);
    @(negedge clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, wd};
    @(negedge clk);
    {d, h} = {reg_rdata, reg_hit};
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~wd};
  endtask
endmodule

// File: dv/egds_status_bank_props.sv
module egds_chk
  import egds_pkg::*;
#(parameter int CODE_W = 6, parameter int NB = 4) (
  // Register side.
  input wire logic clk,
  input wire logic rst_b,
  input wire egds_pkg::egds_rst_e reset_kind,
  input wire logic [6:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_hit,
  // Measurement side.
  input wire logic [NB-1:0] meas_valid,
  input wire logic [NB*CODE_W-1:0] meas_on_code,
  input wire logic [NB*CODE_W-1:0] meas_off_code,
  input wire logic [NB-1:0] meas_regulating,
  input wire logic [NB-1:0] bridge_regulation_flag,
  input wire logic [NB*CODE_W-1:0] bridge_on_delay_code,
  input wire logic [NB*CODE_W-1:0] bridge_off_delay_code
);
  timeunit 1ns / 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // A read that races a clear is left out, since the clear owns the data.
  wire logic map = reg_addr inside {[EGDS_ADDR_HB1:EGDS_ADDR_HB4]};
  wire logic hold = meas_valid == '0 && reset_kind != EGDS_RST_FULL;
  sequence rd_s(a); reg_rd && reg_addr == a && !reset_kind[0]; endsequence
  rsvd_zero_a: assert property (reg_rdata[15:14] == 0 && reg_rdata[7:6] == 0)
    else $error("reserved bits set");
  hit_map_a: assert property (reg_rd || reg_wr |=> reg_hit == $past(map))
    else $error("hit flag wrong");
  hb1_image_a: assert property (rd_s(EGDS_ADDR_HB1) |=> reg_rdata[13:0] ==
    {$past(bridge_off_delay_code[5:0]), 2'b00, $past(bridge_on_delay_code[5:0])})
    else $error("read image wrong");
  unmap_zero_a: assert property (reg_rd && !map |=> reg_rdata == 0)
    else $error("unmapped read not zero");
  code_hold_a: assert property (hold |=> $stable(bridge_on_delay_code) &&
    $stable(bridge_off_delay_code)) else $error("codes moved");
  restart_clr_a: assert property (reset_kind == EGDS_RST_RESTART && !reg_rd |=>
    reg_rdata == 0) else $error("restart left data");
  full_clr_a: assert property (reset_kind == EGDS_RST_FULL |=> reg_rdata == 0 &&
    {bridge_regulation_flag, bridge_on_delay_code, bridge_off_delay_code} == 0)
    else $error("clear incomplete");
  meas_upd_a: assert property (meas_valid[0] && reset_kind != EGDS_RST_FULL |=>
    {bridge_regulation_flag[0], bridge_on_delay_code[5:0], bridge_off_delay_code[5:0]} ==
    {$past(meas_regulating[0]), $past(meas_on_code[5:0]), $past(meas_off_code[5:0])})
    else $error("update wrong");
endmodule
bind egds_status_bank egds_chk #(.CODE_W(CODE_W), .NB(NB)) u_chk (.*);

// File: dv/testbench.sv
`define CHK(x, y) begin total_checks++; if ((x) !== (y)) begin bad_count++; \
  $display("MISMATCH %0t %h %h", $time, x, y); end end
module testbench;
  import egds_pkg::*;
  timeunit 1ns / 1ps;
  logic clk = 0;
  logic rst_b = 0;
  egds_rst_e reset_kind = EGDS_RST_NONE;
  logic [6:0] reg_addr;
  logic reg_rd, reg_wr, reg_hit, h;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [3:0] meas_valid = 0, meas_regulating = 0, bridge_regulation_flag, reg_m = 0;
  logic [23:0] meas_on_code = 0, meas_off_code = 0, bridge_on_delay_code, bridge_off_delay_code;
  logic [23:0] on_m = 0, off_m = 0;
  logic [31:0] seed = 32'hd8ab;
  int bad_count = 0, total_checks = 0, g;
  always #2 clk = ~clk;
  egds_status_bank u_egds_status_bank (.*);
  egds_host u_egds_host (.*);
  // Next value of the fixed-seed shift register.
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Read bridge b and compare with the image the bench keeps.
  task automatic rd_chk(int b);
    u_egds_host.acc(1'b0, EGDS_ADDR_HB1 + 7'(b), 16'h0, d, h);
    `CHK(d, {2'b00, off_m[b*6+:6], 2'b00, on_m[b*6+:6]})
    `CHK(h, 1'b1)
  endtask
  // One measurement pulse; other slices carry noise that must not land.
  task automatic meas(int b);
    seed = lfsr(seed);
    @(negedge clk);
    {meas_regulating, meas_on_code, meas_off_code} = {seed[27:24], seed[23:0], ~seed[31:8]};
    meas_valid = 4'b0001 << b;
    {reg_m[b], on_m[b*6+:6], off_m[b*6+:6]} = {seed[24+b], seed[b*6+:6], ~seed[b*6+8+:6]};
    @(negedge clk);
    meas_valid = 4'h0;
  endtask
  task automatic kind(egds_rst_e k);
    @(negedge clk);
    reset_kind = k;
    @(negedge clk);
    reset_kind = EGDS_RST_NONE;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Reset, fresh reads, random updates, then write, unmapped and clear corners.
  initial begin
    repeat (4) @(negedge clk);
    rst_b = 1;
    for (int b = 0; b < 4; b++) rd_chk(b);
    repeat (40) begin
      seed = lfsr(seed);
      g = seed[1:0];
      meas(g);
      rd_chk(g);
      `CHK(bridge_regulation_flag[g], reg_m[g])
    end
    u_egds_host.acc(1'b1, EGDS_ADDR_HB2, seed[15:0], d, h);
    `CHK(h, 1'b1)
    rd_chk(1);
    u_egds_host.acc(1'b0, 7'h57, 16'h0, d, h);
    `CHK({h, d}, 17'h0)
    kind(EGDS_RST_RESTART);
    `CHK(reg_rdata, 16'h0000)
    rd_chk(3);
    kind(EGDS_RST_FULL);
    {on_m, off_m, reg_m} = '0;
    rd_chk(0);
    `CHK(bridge_regulation_flag, reg_m)
    report_and_stop();
  end
endmodule

// File: rtl/egds_bridge_slot.sv
// One bridge's delay codes, held as a pair so that both update together.
module egds_bridge_slot
  import egds_pkg::*;
#(
  parameter int CODE_W = EGDS_CODE_W
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Reset request and measurement input.
  input wire logic soft_clear,
  input wire logic meas_valid,
  input wire logic [CODE_W-1:0] meas_on_code,
  input wire logic [CODE_W-1:0] meas_off_code,
  input wire logic meas_regulating,
  // Held codes.
  output logic [CODE_W-1:0] on_delay_code,
  output logic [CODE_W-1:0] off_delay_code,
  output logic regulation_flag
);
  logic [CODE_W-1:0] on_reg, on_next, off_reg, off_next;
  logic reg_flag_reg, reg_flag_next;

  // A full clear wins over a measurement in the same cycle; restart never reaches here.
  always_comb begin
    on_next = on_reg;
    off_next = off_reg;
    reg_flag_next = reg_flag_reg;
    if (soft_clear) begin
      on_next = CODE_W'(EGDS_CODE_RESET);
      off_next = CODE_W'(EGDS_CODE_RESET);
      reg_flag_next = 1'b0;
    end else if (meas_valid) begin
      on_next = meas_on_code;
      off_next = meas_off_code;
      reg_flag_next = meas_regulating;
    end
  end

  // Both fields latch on the same edge, so a read never mixes old and new.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      on_reg <= '0;
      off_reg <= '0;
      reg_flag_reg <= 1'b0;
    end else begin
      on_reg <= on_next;
      off_reg <= off_next;
      reg_flag_reg <= reg_flag_next;
    end
  end

  assign on_delay_code = on_reg;
  assign off_delay_code = off_reg;
  assign regulation_flag = reg_flag_reg;
endmodule

// File: rtl/egds_pkg.sv
package egds_pkg;
  // Register addresses in the 7-bit register space.
  localparam logic [6:0] EGDS_ADDR_HB1 = 7'h53;
  localparam logic [6:0] EGDS_ADDR_HB2 = 7'h54;
  localparam logic [6:0] EGDS_ADDR_HB3 = 7'h55;
  localparam logic [6:0] EGDS_ADDR_HB4 = 7'h56;
  localparam int EGDS_ADDR_W = 7;
  localparam int EGDS_DATA_W = 16;
  localparam int EGDS_CODE_W = 6;
  localparam int EGDS_NUM_BRIDGES = 4;
  // Field positions.
  localparam int EGDS_OFF_LSB = 8;
  localparam int EGDS_ON_LSB = 0;
  // Reset values.
  localparam logic [15:0] EGDS_REG_RESET = 16'h0000;
  localparam logic [5:0] EGDS_CODE_RESET = 6'h00;
  // Delay step per code, in picoseconds (53.3 ns).
  localparam int EGDS_STEP_PS = 53300;
  // Reset kinds seen by the bank.
  typedef enum logic [1:0] {
    EGDS_RST_NONE = 2'b00,
    EGDS_RST_FULL = 2'b01,
    EGDS_RST_RESTART = 2'b11
  } egds_rst_e;
endpackage

// File: rtl/egds_status_bank.sv
// Contract
// - Turn-off delay code of each bridge sits in bits 13:8.
// - Turn-on delay code of each bridge sits in bits 5:0.
// - Codes are linear, one step is 53.3 ns, zero means no delay.
// - Bits 15:14 and 7:6 always read as zero.
// - Registers are read-only; writes leave the codes unchanged.
// - Power-on or soft reset clears every bit to zero.
// - Restart zeroes the whole read data register and keeps both delay codes.
// - Bridges one to three decode at 0x53, 0x54 and 0x55.
// - Bridge four decodes at 0x56 with the same layout.
// - Regulation flag is one while either delay is regulated.
module egds_status_bank
  import egds_pkg::*;
#(
  parameter int CODE_W = EGDS_CODE_W,
  parameter int NB = EGDS_NUM_BRIDGES
) (
  // Clock and power-on reset.
  input wire logic clk,
  input wire logic rst_b,
  // Further reset kinds, one-cycle pulses.
  input wire egds_pkg::egds_rst_e reset_kind,
  // Register access from the serial interface frame decoder.
  input wire logic [egds_pkg::EGDS_ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [egds_pkg::EGDS_DATA_W-1:0] reg_wdata,
  output logic [egds_pkg::EGDS_DATA_W-1:0] reg_rdata,
  output logic reg_hit,
  // Measurements from the gate control loop, one valid per bridge.
  input wire logic [NB-1:0] meas_valid,
  input wire logic [NB*CODE_W-1:0] meas_on_code,
  input wire logic [NB*CODE_W-1:0] meas_off_code,
  input wire logic [NB-1:0] meas_regulating,
  // Live view of held state.
  output logic [NB-1:0] bridge_regulation_flag,
  output logic [NB*CODE_W-1:0] bridge_on_delay_code,
  output logic [NB*CODE_W-1:0] bridge_off_delay_code
);
  import egds_pkg::*;

  logic soft_clear;
  logic [NB*CODE_W-1:0] on_codes, off_codes;
  logic [EGDS_DATA_W-1:0] rdata_reg, rdata_next;
  logic hit_reg, hit_next;

  // Restart is deliberately not routed to the slots so the codes survive it.
  assign soft_clear = (reset_kind == EGDS_RST_FULL);

  // Map an address to a bridge index; returns NB when unmapped.
  function automatic int unsigned bridge_of(input logic [EGDS_ADDR_W-1:0] a);
    unique case (a)
      EGDS_ADDR_HB1: bridge_of = 0;
      EGDS_ADDR_HB2: bridge_of = 1;
      EGDS_ADDR_HB3: bridge_of = 2;
      EGDS_ADDR_HB4: bridge_of = 3;
      default: bridge_of = NB;
    endcase
  endfunction

  // Pack one bridge's codes into the register image with reserved bits zero.
  function automatic logic [EGDS_DATA_W-1:0] pack(input logic [CODE_W-1:0] on_c,
                                                   input logic [CODE_W-1:0] off_c);
    pack = '0;
    pack[EGDS_OFF_LSB +: CODE_W] = off_c;
    pack[EGDS_ON_LSB +: CODE_W] = on_c;
  endfunction

  // One slot per bridge.
  for (genvar g = 0; g < NB; g++) begin : g_slot
    egds_bridge_slot #(.CODE_W(CODE_W)) u_slot (
      .clk(clk),
      .rst_b(rst_b),
      .soft_clear(soft_clear),
      .meas_valid(meas_valid[g]),
      .meas_on_code(meas_on_code[g*CODE_W +: CODE_W]),
      .meas_off_code(meas_off_code[g*CODE_W +: CODE_W]),
      .meas_regulating(meas_regulating[g]),
      .on_delay_code(on_codes[g*CODE_W +: CODE_W]),
      .off_delay_code(off_codes[g*CODE_W +: CODE_W]),
      .regulation_flag(bridge_regulation_flag[g])
    );
  end

  // Read data is captured on the read strobe; writes are acknowledged but ignored.
  always_comb begin
    int unsigned idx;
    idx = bridge_of(reg_addr);
    rdata_next = rdata_reg;
    hit_next = 1'b0;
    if (reg_rd || reg_wr) begin
      hit_next = (idx < NB);
    end
    if (reg_rd) begin
      if (idx < NB) begin
        rdata_next = pack(on_codes[idx*CODE_W +: CODE_W], off_codes[idx*CODE_W +: CODE_W]);
      end else begin
        rdata_next = EGDS_REG_RESET;
      end
    end
    if (soft_clear || reset_kind == EGDS_RST_RESTART) begin
      rdata_next = EGDS_REG_RESET;
    end
  end

  // Write data has no path into the slots, so codes cannot be disturbed.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= EGDS_REG_RESET;
      hit_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      hit_reg <= hit_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_hit = hit_reg;
  assign bridge_on_delay_code = on_codes;
  assign bridge_off_delay_code = off_codes;
endmodule
